// File: rtl/adp_pkg.sv
package adp_pkg;

	// ----------------------------------------------------------------
	// Fetch addresses
	// ----------------------------------------------------------------
	localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;
	localparam logic [31:0] EXCEPTION_VECTOR = 32'h0000_0008;
	localparam logic [31:0] INTERRUPT_VECTOR = 32'h0000_0010;
	localparam logic [31:0] FETCH_STEP = 32'h0000_0004;

	// ----------------------------------------------------------------
	// Instruction fields, bit 0 is the most significant bit
	// ----------------------------------------------------------------
	localparam int OPCODE_POS = 0;
	localparam int DEST_POS = 6;
	localparam int SRC_A_POS = 11;
	localparam int SRC_B_POS = 16;
	localparam int REST_POS = 21;
	localparam int LITERAL_POS = 16;
	localparam int HOLD_FLAG_BIT = 3;
	localparam int CARRY_SEL_BIT = 4;

	// Opcode family with bits 3 and 4 cleared
	localparam logic [5:0] ADD_REG_BASE = 6'h00;
	localparam logic [5:0] ADD_IMM_BASE = 6'h10;
	localparam logic [5:0] VARIANT_MASK = 6'h39;
	localparam logic [5:0] PREFIX_OPCODE = 6'h2C;
	localparam logic [4:0] ZERO_REG = 5'h00;
	localparam logic ARITH_FLAG_RESET = 1'h0;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [5:0] opcode;
		logic [4:0] destField;
		logic [4:0] firstSrcField;
		logic [4:0] secondSrcField;
		logic [10:0] restField;
	} adp_rr_word_t;

	typedef struct packed {
		logic [5:0] opcode;
		logic [4:0] destField;
		logic [4:0] firstSrcField;
		logic [15:0] literalField;
	} adp_ri_word_t;

	typedef struct packed {
		logic valid;
		logic [31:0] word;
	} adp_instr_t;

	typedef struct packed {
		logic writeEn;
		logic [4:0] dest;
		logic [31:0] data;
	} adp_wb_t;

endpackage

// File: rtl/adp_add_datapath.sv
// Behaviour
// - After reset, fetch starts at address zero.
// - A taken exception sends the program counter to address eight.
// - A taken interrupt sends the program counter to address 0x10.
// - Register format: opcode 0, destination 6, sources 11 and 16, rest 21.
// - Immediate format: opcode, destination 6, source 11, 16-bit literal at 16.
// - Register sum writes first plus second source into destination.
// - Opcode bit 3 set leaves the arithmetic flag unchanged.
// - Opcode bit 3 clear loads sum carry-out into the arithmetic flag.
// - Opcode bit 4 set adds the arithmetic flag as carry-in.
// - Register variants: hold sets bit 3, carry-in bit 4, combined both.
// - Immediate sum adds first source and sign-extended literal.
// - Immediate variants use the same bit 3 and bit 4 encoding.
// - Opcode carry-in select is distinct from the stored arithmetic flag.
// - After an immediate prefix, the literal joins the prefix into 32 bits.
module adp_add_datapath (
	input wire logic mclk,
	input wire logic srst,
	input wire adp_pkg::adp_instr_t instr,
	input wire logic takeException,
	input wire logic takeInterrupt,
	input wire logic stall,
	output logic [31:0] fetchAddr,
	output logic [4:0] srcAddrA,
	output logic [4:0] srcAddrB,
	input wire logic [31:0] srcDataA,
	input wire logic [31:0] srcDataB,
	output adp_pkg::adp_wb_t writeBack,
	output logic [31:0] machineStatusWord,
	output logic arithmeticFlag
);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	adp_pkg::adp_rr_word_t rrWord;
	adp_pkg::adp_ri_word_t riWord;
	logic [5:0] opFamily;
	logic isRegSum;
	logic isImmSum;
	logic isPrefix;
	logic holdFlag;
	logic carrySel;
	logic isSum;
	logic instrFire;
	logic sumFire;
	logic flagLoad;

	assign rrWord = adp_pkg::adp_rr_word_t'(instr.word);
	assign riWord = adp_pkg::adp_ri_word_t'(instr.word);
	// Clearing the two variant bits leaves the family code
	assign opFamily = rrWord.opcode & adp_pkg::VARIANT_MASK;
	assign isRegSum = instr.valid && opFamily == adp_pkg::ADD_REG_BASE;
	assign isImmSum = instr.valid && opFamily == adp_pkg::ADD_IMM_BASE;
	assign isSum = isRegSum || isImmSum;
	assign isPrefix = instr.valid && rrWord.opcode == adp_pkg::PREFIX_OPCODE;
	// Opcode bit n sits at vector bit 5-n because bit 0 is the MSB
	assign holdFlag = rrWord.opcode[5 - adp_pkg::HOLD_FLAG_BIT];
	assign carrySel = rrWord.opcode[5 - adp_pkg::CARRY_SEL_BIT];
	assign srcAddrA = rrWord.firstSrcField;
	assign srcAddrB = rrWord.secondSrcField;

	// An instruction retires only on an edge without stall
	assign instrFire = instr.valid && !stall;
	assign sumFire = instrFire && isSum;
	assign flagLoad = sumFire && !holdFlag;

	// ----------------------------------------------------------------
	// Immediate prefix
	// ----------------------------------------------------------------
	logic prefixValid_reg;
	logic [15:0] prefixHigh_reg;

	always_ff @(posedge mclk) begin
		if (srst) begin
			prefixValid_reg <= 1'b0;
		end else if (instrFire) begin
			// Any valid instruction without stall consumes a pending prefix
			prefixValid_reg <= isPrefix;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			prefixHigh_reg <= 16'h0000;
		end else if (instrFire && isPrefix) begin
			prefixHigh_reg <= riWord.literalField;
		end
	end

	// ----------------------------------------------------------------
	// Adder
	// ----------------------------------------------------------------
	logic arithFlag_reg;
	logic [31:0] sextLiteral;
	logic [31:0] joinedLiteral;
	logic [31:0] immOperand;
	logic [31:0] operandB;
	logic carryIn;
	logic [32:0] sumWide;
	logic [31:0] sumResult;
	logic carryOut;

	assign sextLiteral = {{16{riWord.literalField[15]}}, riWord.literalField};
	assign joinedLiteral = {prefixHigh_reg, riWord.literalField};

	always_comb begin
		if (prefixValid_reg) begin
			immOperand = joinedLiteral;
		end else begin
			immOperand = sextLiteral;
		end
		operandB = isImmSum ? immOperand : srcDataB;
		// Select bit gates the stored flag; they never alias
		carryIn = carrySel & arithFlag_reg;
		sumWide = {1'b0, srcDataA} + {1'b0, operandB} + {32'h0000_0000, carryIn};
	end

	// Carry-out is the bit above the most significant sum bit
	assign sumResult = sumWide[31:0];
	assign carryOut = sumWide[32];

	// ----------------------------------------------------------------
	// Result and flag, one cycle
	// ----------------------------------------------------------------
	logic wbEn_reg;
	logic [4:0] wbDest_reg;
	logic [31:0] wbData_reg;

	always_ff @(posedge mclk) begin
		if (srst) begin
			wbEn_reg <= 1'b0;
		end else begin
			wbEn_reg <= sumFire;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			wbDest_reg <= 5'h00;
		end else begin
			wbDest_reg <= rrWord.destField;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			wbData_reg <= 32'h0000_0000;
		end else begin
			wbData_reg <= sumResult;
		end
	end

	assign writeBack = {wbEn_reg, wbDest_reg, wbData_reg};

	// Flag and destination change on the same edge
	always_ff @(posedge mclk) begin
		if (srst) begin
			arithFlag_reg <= adp_pkg::ARITH_FLAG_RESET;
		end else if (flagLoad) begin
			arithFlag_reg <= carryOut;
		end
	end

	assign arithmeticFlag = arithFlag_reg;
	// Only the carry position of the status word is held here
	assign machineStatusWord = {arithFlag_reg, 31'h0000_0000};

	// ----------------------------------------------------------------
	// Fetch address
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ADP_PC_HOLD = 2'h0,
		ADP_PC_STEP = 2'h1,
		ADP_PC_EXC = 2'h2,
		ADP_PC_IRQ = 2'h3
	} adp_pc_sel_t;

	adp_pc_sel_t pcSel;
	logic [31:0] pc_reg;
	logic [31:0] pc_next;

	// Exception outranks interrupt; both outrank the sequential step
	always_comb begin
		if (takeException) begin
			pcSel = ADP_PC_EXC;
		end else if (takeInterrupt) begin
			pcSel = ADP_PC_IRQ;
		end else if (!stall) begin
			pcSel = ADP_PC_STEP;
		end else begin
			pcSel = ADP_PC_HOLD;
		end
	end

	always_comb begin
		case (pcSel)
			ADP_PC_HOLD: begin
				pc_next = pc_reg;
			end
			ADP_PC_STEP: begin
				pc_next = pc_reg + adp_pkg::FETCH_STEP;
			end
			ADP_PC_EXC: begin
				pc_next = adp_pkg::EXCEPTION_VECTOR;
			end
			ADP_PC_IRQ: begin
				pc_next = adp_pkg::INTERRUPT_VECTOR;
			end
			default: begin
				pc_next = pc_reg;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			pc_reg <= adp_pkg::RESET_VECTOR;
		end else begin
			pc_reg <= pc_next;
		end
	end

	assign fetchAddr = pc_reg;

endmodule

// File: test/adp_add_datapath_asserts.sv
module adp_add_datapath_asserts (
	input wire logic mclk,
	input wire logic srst,
	input wire adp_pkg::adp_instr_t instr,
	input wire logic takeException,
	input wire logic takeInterrupt,
	input wire logic stall,
	input wire logic [31:0] fetchAddr,
	input wire logic [4:0] srcAddrA,
	input wire logic [4:0] srcAddrB,
	input wire logic [31:0] srcDataA,
	input wire logic [31:0] srcDataB,
	input wire adp_pkg::adp_wb_t writeBack,
	input wire logic [31:0] machineStatusWord,
	input wire logic arithmeticFlag
);
	logic [32:0] sumReg;
	logic go;
	assign go = instr.valid && !stall;
	always_ff @(posedge mclk) sumReg <= srcDataA + srcDataB + (instr.word[27] & arithmeticFlag);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	chk_reset_fetch: assert property ($past(srst) |-> fetchAddr == 32'h0) else $error("rst");
	chk_exc_vector: assert property (takeException |=> fetchAddr == 32'h8) else $error("exc");
	chk_irq_vector: assert property (
		takeInterrupt && !takeException |=> fetchAddr == 32'h10) else $error("irq");
	chk_src_fields: assert property (
		srcAddrA == instr.word[20:16] && srcAddrB == instr.word[15:11]) else $error("fields");
	chk_hold_flag: assert property (
		go && instr.word[28] |=> $stable(arithmeticFlag)) else $error("hold");
	chk_reg_sum: assert property (
		go && (instr.word[31:26] & 6'h39) == 6'h00
		|=> writeBack.writeEn && writeBack.data == sumReg[31:0]) else $error("sum");
	chk_carry_out: assert property (
		go && (instr.word[31:26] & 6'h3D) == 6'h00
		|=> arithmeticFlag == sumReg[32]) else $error("carry");
	chk_status_word: assert property (
		machineStatusWord == {arithmeticFlag, 31'h0}) else $error("msw");
	chk_stall_write: assert property (stall |=> !writeBack.writeEn) else $error("stall");
endmodule

// File: test/tb_add_datapath_and_vectors.sv
module tb_add_datapath_and_vectors;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	adp_pkg::adp_instr_t instr = '0;
	logic takeException = 1'b0;
	logic takeInterrupt = 1'b0;
	logic stall = 1'b0;
	logic [31:0] srcDataA = 32'h0;
	logic [31:0] srcDataB = 32'h1;
	logic [31:0] fetchAddr;
	logic [4:0] srcAddrA;
	logic [4:0] srcAddrB;
	adp_pkg::adp_wb_t writeBack;
	logic [31:0] machineStatusWord;
	logic arithmeticFlag;
	int err_count = 0;
	int checks_done = 0;
	// ----------------------------------------------------------------
	// Rows: opcode, low half, first source, sum, flag after
	// ----------------------------------------------------------------
	logic [86:0] rows [8] = '{
		{6'h00, 16'h1000, 32'hFFFFFFFF, 32'h0, 1'b1},
		{6'h04, 16'h1000, 32'h1, 32'h2, 1'b1},
		{6'h06, 16'h1000, 32'h1, 32'h3, 1'b1},
		{6'h02, 16'h1000, 32'hFFFFFFFE, 32'h0, 1'b1},
		{6'h10, 16'hFFFF, 32'h2, 32'h1, 1'b1},
		{6'h12, 16'h0001, 32'h1, 32'h3, 1'b0},
		{6'h14, 16'h8000, 32'h0, 32'hFFFF8000, 1'b0},
		{6'h16, 16'h7FFF, 32'h1, 32'h8000, 1'b0}};
	always #5 mclk = ~mclk;
	adp_add_datapath uut (.*);
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Destination 3, first source 1, one cycle of valid
	task automatic run(input logic [21:0] cmd, input logic [31:0] a);
		@(posedge mclk);
		#1 instr = {1'b1, cmd[21:16], 10'h061, cmd[15:0]};
		srcDataA = a;
		@(posedge mclk);
		#1 instr.valid = 1'b0;
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#20000;
		err_count++;
		finish_test();
	end
	initial begin
		repeat (8) @(posedge mclk);
		#1 srst = 1'b0;
		cmp(fetchAddr, 32'h0);
		foreach (rows[i]) begin
			run(rows[i][86:65], rows[i][64:33]);
			cmp(writeBack.data, rows[i][32:1]);
			cmp(32'(arithmeticFlag), 32'(rows[i][0]));
			cmp(32'({writeBack.writeEn, writeBack.dest}), 32'h23);
		end
		stall = 1'b1;
		run(22'h001000, 32'hFFFFFFFF);
		cmp(32'({writeBack.writeEn, arithmeticFlag}), 32'h0);
		stall = 1'b0;
		run(22'h2C1234, 32'h0);
		run(22'h105678, 32'h1);
		cmp(writeBack.data, 32'h12345679);
		cmp(32'(srcAddrA), 32'h1);
		takeException = 1'b1;
		takeInterrupt = 1'b1;
		@(posedge mclk);
		#1 takeException = 1'b0;
		cmp(fetchAddr, 32'h8);
		@(posedge mclk);
		#1 takeInterrupt = 1'b0;
		cmp(fetchAddr, 32'h10);
		srst = 1'b1;
		@(posedge mclk);
		#1 srst = 1'b0;
		cmp(fetchAddr, 32'h0);
		finish_test();
	end
endmodule
bind adp_add_datapath adp_add_datapath_asserts chk (
	.mclk(mclk),
	.srst(srst),
	.instr(instr),
	.takeException(takeException),
	.takeInterrupt(takeInterrupt),
	.stall(stall),
	.fetchAddr(fetchAddr),
	.srcAddrA(srcAddrA),
	.srcAddrB(srcAddrB),
	.srcDataA(srcDataA),
	.srcDataB(srcDataB),
	.writeBack(writeBack),
	.machineStatusWord(machineStatusWord),
	.arithmeticFlag(arithmeticFlag)
);
